// ==== pkg/etp_pkg.sv ====
// constants, field layout and timing for the energy to pulse converter
// What this block does
// - divider 0 or 1: one quantum per LSB
// - output pulse after denominator/numerator quanta
// - select 00 active, 01 reactive, 1x apparent
// - shared bit 3 picks current rms or apparent
// - never apparent on one, rms on other
// - config one bits 1,2 disable outputs
// - output pulses set status bits 6, 7
// - enabled set flag raises energy interrupt
// - disabled event never raises the interrupt
// - interrupt holds until flag is cleared
// - write 0 clears flag, 1 keeps it
// - period over 180 ms: 90 ms low
// - period under 180 ms: 50% duty
// - both pulse outputs are active low
// - 16-bit unsigned numerator and denominator
// - zero scaling register acts as one
// - numerator above denominator clamps ratio to one
// - full scale unscaled output near 21.1 kHz
// - one shared energy interrupt line, three enables
package etp_pkg;

  // ==========================================================
  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // ==========================================================
  // register offsets
  localparam logic [7:0] OFF_CONFIG_ONE = 8'h0b;
  localparam logic [7:0] OFF_CONFIG_TWO = 8'h0c;
  localparam logic [7:0] OFF_DIVIDER = 8'h24;
  localparam logic [7:0] OFF_NUM_A = 8'h27;
  localparam logic [7:0] OFF_DEN_A = 8'h28;
  localparam logic [7:0] OFF_NUM_B = 8'h29;
  localparam logic [7:0] OFF_DEN_B = 8'h2a;
  localparam logic [7:0] OFF_PULSE_STATE = 8'h2b;
  localparam logic [7:0] OFF_COUNT_A = 8'h2c;
  localparam logic [7:0] OFF_COUNT_B = 8'h2d;
  localparam logic [7:0] OFF_IRQ_EN_LOW = 8'hd9;
  localparam logic [7:0] OFF_IRQ_EN_MID = 8'hda;
  localparam logic [7:0] OFF_IRQ_EN_HIGH = 8'hdb;
  localparam logic [7:0] OFF_IRQ_STATUS_MID = 8'hdd;

  // ==========================================================
  // field positions
  localparam int DIS_A_BIT = 1;
  localparam int DIS_B_BIT = 2;
  localparam int AHR_SEL_BIT = 3;
  localparam int SEL_A_LSB = 4;
  localparam int SEL_B_LSB = 6;
  localparam int FLAG_A_BIT = 6;
  localparam int FLAG_B_BIT = 7;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_CONFIG_ONE = 8'h00;
  localparam logic [7:0] RST_CONFIG_TWO = 8'h00;
  localparam logic [7:0] RST_DIVIDER = 8'h00;
  localparam logic [15:0] RST_SCALE = 16'h0000;
  localparam logic [7:0] RST_IRQ_EN = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h00;

  // ==========================================================
  // interrupt vector shared by all energy events
  localparam logic [15:0] ENERGY_IRQ_VECTOR = 16'h004b;

  // ==========================================================
  // timing
  localparam int CLK_HZ = 50_000_000;
  localparam int LOW_TIME_MS = 90;
  localparam int LONG_PERIOD_MS = 180;
  localparam int LOW_CYCLES = CLK_HZ / 1000 * LOW_TIME_MS;
  localparam int LONG_PERIOD_CYCLES = CLK_HZ / 1000 * LONG_PERIOD_MS;
  localparam int CNT_W = 24;

  typedef enum logic [0:0] {
    ETP_OUT_IDLE = 1'b0,
    ETP_OUT_LOW = 1'b1
  } etp_shape_t;

endpackage

// ==== design/etp_dfc.sv ====
// rate scaler: numerator/denominator accumulator over energy quanta
`timescale 1ns/1ns
module etp_dfc (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // quanta in
  input wire logic quantum,
  input wire logic enable,
  // scaling
  input wire logic [15:0] numerator,
  input wire logic [15:0] denominator,
  // scaled pulse out
  output logic scaled_pulse,
  output logic clamped
);
  import etp_pkg::*;

  logic [15:0] num_eff;
  logic [15:0] den_eff;
  logic [16:0] acc_reg;
  logic [16:0] sum;

  // ==========================================================
  // effective ratio
  always_comb begin
    num_eff = (numerator == 16'h0000) ? 16'h0001 : numerator;
    den_eff = (denominator == 16'h0000) ? 16'h0001 : denominator;
    clamped = 1'b0;
    if (num_eff > den_eff) begin
      num_eff = den_eff;
      clamped = 1'b1;
    end
    sum = acc_reg + {1'b0, num_eff};
  end

  // ==========================================================
  // remainder stays below den, so one quantum gives at most one pulse
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      acc_reg <= 17'h00000;
      scaled_pulse <= 1'b0;
    end else if (!enable) begin
      acc_reg <= 17'h00000;
      scaled_pulse <= 1'b0;
    end else if (quantum) begin
      if (sum >= {1'b0, den_eff}) begin
        acc_reg <= sum - {1'b0, den_eff};
        scaled_pulse <= 1'b1;
      end else begin
        acc_reg <= sum;
        scaled_pulse <= 1'b0;
      end
    end else begin
      scaled_pulse <= 1'b0;
    end
  end

endmodule

// ==== design/etp_pulse_shaper.sv ====
// shapes scaled pulses into the active-low calibration output
`timescale 1ns/1ns
module etp_pulse_shaper #(
  parameter int LOW_CYC = 4500000,
  parameter int LONG_CYC = 9000000
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // control
  input wire logic enable,
  input wire logic trigger,
  // pin
  output logic out_n
);
  import etp_pkg::*;

  localparam logic [23:0] LOW_LEN = 24'(LOW_CYC);
  localparam logic [23:0] LONG_LEN = 24'(LONG_CYC);

  etp_shape_t state_reg;
  logic [23:0] since_reg;
  logic [23:0] left_reg;
  logic [23:0] low_len;

  // long periods get the fixed low time, short ones half the last period
  always_comb begin
    if (since_reg >= LONG_LEN) begin
      low_len = LOW_LEN;
    end else if (since_reg[23:1] == 23'h000000) begin
      low_len = 24'h000001;
    end else begin
      low_len = {1'b0, since_reg[23:1]};
    end
  end

  // ==========================================================
  // period measurement, saturating so a first pulse counts as long
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      since_reg <= LONG_LEN;
    end else if (trigger) begin
      since_reg <= 24'h000001;
    end else if (since_reg < LONG_LEN) begin
      since_reg <= since_reg + 24'h000001;
    end
  end

  // ==========================================================
  // low phase
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ETP_OUT_IDLE;
      left_reg <= 24'h000000;
      out_n <= 1'b1;
    end else if (!enable) begin
      state_reg <= ETP_OUT_IDLE;
      left_reg <= 24'h000000;
      out_n <= 1'b1;
    end else if (trigger) begin
      state_reg <= ETP_OUT_LOW;
      left_reg <= low_len - 24'h000001;
      out_n <= 1'b0;
    end else begin
      unique case (state_reg)
        ETP_OUT_IDLE: begin
          out_n <= 1'b1;
        end
        ETP_OUT_LOW: begin
          if (left_reg == 24'h000000) begin
            state_reg <= ETP_OUT_IDLE;
            out_n <= 1'b1;
          end else begin
            left_reg <= left_reg - 24'h000001;
          end
        end
      endcase
    end
  end

endmodule

// ==== design/etp_converter.sv ====
// top of the energy to pulse converter: registers, source select, two channels
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ns
module etp_converter #(
  parameter int LOW_CYC = etp_pkg::LOW_CYCLES,
  parameter int LONG_CYC = etp_pkg::LONG_PERIOD_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // register port
  input wire logic [etp_pkg::ADDR_W-1:0] addr,
  input wire logic [etp_pkg::DATA_W-1:0] wr_data,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  output logic [etp_pkg::DATA_W-1:0] rd_data,
  // energy quanta, one-cycle pulses per accumulated LSB
  input wire logic active_quantum,
  input wire logic reactive_quantum,
  input wire logic apparent_quantum,
  input wire logic irms_quantum,
  // calibration pins, active low
  output logic pulse_out_a,
  output logic pulse_out_b,
  // energy interrupt request to the core
  output logic energy_irq
);
  import etp_pkg::*;

  // ==========================================================
  // register storage
  logic [7:0] measure_config_one_reg;
  logic [7:0] measure_config_two_reg;
  logic [7:0] active_energy_divider_reg;
  logic [15:0] pulse_scale_numerator_reg [2];
  logic [15:0] pulse_scale_denominator_reg [2];
  logic [7:0] energy_irq_enable_low_reg;
  logic [7:0] energy_irq_enable_mid_reg;
  logic [7:0] energy_irq_enable_high_reg;
  logic [7:0] energy_irq_status_mid_reg;
  logic [7:0] energy_irq_status_mid_next;
  logic [15:0] pulse_count_reg [2];
  logic [DATA_W-1:0] rd_data_next;
  logic energy_irq_next;

  // ==========================================================
  // write decode
  logic wr_config_one;
  logic wr_config_two;
  logic wr_divider;
  logic wr_en_low;
  logic wr_en_mid;
  logic wr_en_high;
  logic wr_status_mid;
  logic [1:0] wr_num;
  logic [1:0] wr_den;

  always_comb begin
    wr_config_one = wr_strobe && (addr == OFF_CONFIG_ONE);
    wr_config_two = wr_strobe && (addr == OFF_CONFIG_TWO);
    wr_divider = wr_strobe && (addr == OFF_DIVIDER);
    wr_en_low = wr_strobe && (addr == OFF_IRQ_EN_LOW);
    wr_en_mid = wr_strobe && (addr == OFF_IRQ_EN_MID);
    wr_en_high = wr_strobe && (addr == OFF_IRQ_EN_HIGH);
    wr_status_mid = wr_strobe && (addr == OFF_IRQ_STATUS_MID);
    wr_num[0] = wr_strobe && (addr == OFF_NUM_A);
    wr_num[1] = wr_strobe && (addr == OFF_NUM_B);
    wr_den[0] = wr_strobe && (addr == OFF_DEN_A);
    wr_den[1] = wr_strobe && (addr == OFF_DEN_B);
  end

  // ==========================================================
  // configuration registers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      measure_config_one_reg <= RST_CONFIG_ONE;
    end else if (wr_config_one) begin
      measure_config_one_reg <= wr_data[7:0];
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      measure_config_two_reg <= RST_CONFIG_TWO;
    end else if (wr_config_two) begin
      measure_config_two_reg <= wr_data[7:0];
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      active_energy_divider_reg <= RST_DIVIDER;
    end else if (wr_divider) begin
      active_energy_divider_reg <= wr_data[7:0];
    end
  end

  // ==========================================================
  // interrupt enables; low and high hold other energy events kept elsewhere
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      energy_irq_enable_low_reg <= RST_IRQ_EN;
      energy_irq_enable_mid_reg <= RST_IRQ_EN;
      energy_irq_enable_high_reg <= RST_IRQ_EN;
    end else begin
      if (wr_en_low) begin
        energy_irq_enable_low_reg <= wr_data[7:0];
      end
      if (wr_en_mid) begin
        energy_irq_enable_mid_reg <= wr_data[7:0];
      end
      if (wr_en_high) begin
        energy_irq_enable_high_reg <= wr_data[7:0];
      end
    end
  end

  // ==========================================================
  // active-quantum prescaler; only the active path has a divider
  logic [7:0] div_count_reg;
  logic active_div_quantum;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      div_count_reg <= 8'h00;
      active_div_quantum <= 1'b0;
    end else if (active_energy_divider_reg <= 8'h01) begin
      div_count_reg <= 8'h00;
      active_div_quantum <= active_quantum;
    end else if (active_quantum) begin
      if (div_count_reg >= active_energy_divider_reg - 8'h01) begin
        div_count_reg <= 8'h00;
        active_div_quantum <= 1'b1;
      end else begin
        div_count_reg <= div_count_reg + 8'h01;
        active_div_quantum <= 1'b0;
      end
    end else begin
      active_div_quantum <= 1'b0;
    end
  end

  // the other quanta take one cycle too, so every source has equal latency
  logic reactive_q_reg;
  logic apparent_q_reg;
  logic irms_q_reg;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      reactive_q_reg <= 1'b0;
      apparent_q_reg <= 1'b0;
      irms_q_reg <= 1'b0;
    end else begin
      reactive_q_reg <= reactive_quantum;
      apparent_q_reg <= apparent_quantum;
      irms_q_reg <= irms_quantum;
    end
  end

  // ==========================================================
  // channels: source select, scaler, shaper
  logic [1:0] out_enable;
  logic [1:0] scaled_pulse;
  logic [1:0] clamped;
  logic [1:0] pin_level;
  logic ampere_hour_select;

  // one select bit serves both channels, so the 1x choice always agrees
  assign ampere_hour_select = measure_config_two_reg[AHR_SEL_BIT];
  assign out_enable[0] = ~measure_config_one_reg[DIS_A_BIT];
  assign out_enable[1] = ~measure_config_one_reg[DIS_B_BIT];

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      localparam int SEL_LSB = (ch == 0) ? SEL_A_LSB : SEL_B_LSB;
      logic [1:0] pulse_source_select;
      logic chosen_quantum;

      assign pulse_source_select = measure_config_two_reg[SEL_LSB +: 2];

      always_comb begin
        if (pulse_source_select[1]) begin
          chosen_quantum = ampere_hour_select ? irms_q_reg : apparent_q_reg;
        end else if (pulse_source_select[0]) begin
          chosen_quantum = reactive_q_reg;
        end else begin
          chosen_quantum = active_div_quantum;
        end
      end

      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          pulse_scale_numerator_reg[ch] <= RST_SCALE;
        end else if (wr_num[ch]) begin
          pulse_scale_numerator_reg[ch] <= wr_data;
        end
      end

      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          pulse_scale_denominator_reg[ch] <= RST_SCALE;
        end else if (wr_den[ch]) begin
          pulse_scale_denominator_reg[ch] <= wr_data;
        end
      end

      etp_dfc u_dfc (
        .clock(clock),
        .reset_n(reset_n),
        .quantum(chosen_quantum),
        .enable(out_enable[ch]),
        .numerator(pulse_scale_numerator_reg[ch]),
        .denominator(pulse_scale_denominator_reg[ch]),
        .scaled_pulse(scaled_pulse[ch]),
        .clamped(clamped[ch])
      );

      // unity ratio passes every quantum, which sets the top output rate
      etp_pulse_shaper #(
        .LOW_CYC(LOW_CYC),
        .LONG_CYC(LONG_CYC)
      ) u_shaper (
        .clock(clock),
        .reset_n(reset_n),
        .enable(out_enable[ch]),
        .trigger(scaled_pulse[ch]),
        .out_n(pin_level[ch])
      );

      // free-running count of output pulses, wraps at 16 bits
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          pulse_count_reg[ch] <= 16'h0000;
        end else if (scaled_pulse[ch]) begin
          pulse_count_reg[ch] <= pulse_count_reg[ch] + 16'h0001;
        end
      end
    end
  endgenerate

  assign pulse_out_a = pin_level[0];
  assign pulse_out_b = pin_level[1];

  // ==========================================================
  // status flags: a pulse in the clearing cycle survives the clear
  always_comb begin
    energy_irq_status_mid_next = energy_irq_status_mid_reg;
    if (wr_status_mid) begin
      energy_irq_status_mid_next[FLAG_A_BIT] = energy_irq_status_mid_reg[FLAG_A_BIT] & wr_data[FLAG_A_BIT];
      energy_irq_status_mid_next[FLAG_B_BIT] = energy_irq_status_mid_reg[FLAG_B_BIT] & wr_data[FLAG_B_BIT];
    end
    if (scaled_pulse[0]) begin
      energy_irq_status_mid_next[FLAG_A_BIT] = 1'b1;
    end
    if (scaled_pulse[1]) begin
      energy_irq_status_mid_next[FLAG_B_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      energy_irq_status_mid_reg <= RST_STATUS;
    end else begin
      energy_irq_status_mid_reg <= energy_irq_status_mid_next;
    end
  end

  // ==========================================================
  // interrupt request: level while any enabled flag stands
  always_comb begin
    energy_irq_next = |(energy_irq_status_mid_reg & energy_irq_enable_mid_reg
                        & ((8'h01 << FLAG_A_BIT) | (8'h01 << FLAG_B_BIT)));
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      energy_irq <= 1'b0;
    end else begin
      energy_irq <= energy_irq_next;
    end
  end

  // ==========================================================
  // read path: data only in the cycle after the strobe
  always_comb begin
    rd_data_next = '0;
    if (rd_strobe) begin
      unique case (addr)
        OFF_CONFIG_ONE: rd_data_next = {8'h00, measure_config_one_reg};
        OFF_CONFIG_TWO: rd_data_next = {8'h00, measure_config_two_reg};
        OFF_DIVIDER: rd_data_next = {8'h00, active_energy_divider_reg};
        OFF_NUM_A: rd_data_next = pulse_scale_numerator_reg[0];
        OFF_DEN_A: rd_data_next = pulse_scale_denominator_reg[0];
        OFF_NUM_B: rd_data_next = pulse_scale_numerator_reg[1];
        OFF_DEN_B: rd_data_next = pulse_scale_denominator_reg[1];
        OFF_PULSE_STATE: rd_data_next = {10'h000, clamped, out_enable, pin_level};
        OFF_COUNT_A: rd_data_next = pulse_count_reg[0];
        OFF_COUNT_B: rd_data_next = pulse_count_reg[1];
        OFF_IRQ_EN_LOW: rd_data_next = {8'h00, energy_irq_enable_low_reg};
        OFF_IRQ_EN_MID: rd_data_next = {8'h00, energy_irq_enable_mid_reg};
        OFF_IRQ_EN_HIGH: rd_data_next = {8'h00, energy_irq_enable_high_reg};
        OFF_IRQ_STATUS_MID: rd_data_next = {8'h00, energy_irq_status_mid_reg};
        default: rd_data_next = '0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rd_data <= '0;
    end else begin
      rd_data <= rd_data_next;
    end
  end

endmodule

// ==== testbench/etp_cal_meter.sv ====
// calibration meter model: counts active-low pulses and times the last low phase
`timescale 1ns/1ns
module etp_cal_meter (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // calibration pins
  input wire logic pin_a,
  input wire logic pin_b,
  // results
  output logic [15:0] count_a,
  output logic [15:0] count_b,
  output logic [15:0] low_a,
  output logic [15:0] low_b
);
  logic [15:0] run_a;
  logic [15:0] run_b;
  logic prev_a;
  logic prev_b;
  // a falling edge marks the start of one pulse, the low phase is the pulse
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      {count_a, count_b, low_a, low_b, run_a, run_b} <= '0;
      {prev_a, prev_b} <= 2'b11;
    end else begin
      prev_a <= pin_a;
      prev_b <= pin_b;
      if (prev_a && !pin_a) count_a <= count_a + 16'h0001;
      if (prev_b && !pin_b) count_b <= count_b + 16'h0001;
      run_a <= pin_a ? 16'h0000 : run_a + 16'h0001;
      run_b <= pin_b ? 16'h0000 : run_b + 16'h0001;
      if (!prev_a && pin_a) low_a <= run_a;
      if (!prev_b && pin_b) low_b <= run_b;
    end
  end
endmodule

// ==== testbench/etp_converter_asserts.sv ====
// port-level assertions for the energy to pulse converter
`timescale 1ns/1ns
module etp_converter_asserts #(
  parameter int LOW_CYC = 20,
  parameter int LONG_CYC = 40
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // register port
  input wire logic [etp_pkg::ADDR_W-1:0] addr,
  input wire logic [etp_pkg::DATA_W-1:0] wr_data,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  input wire logic [etp_pkg::DATA_W-1:0] rd_data,
  // quanta
  input wire logic active_quantum,
  input wire logic reactive_quantum,
  input wire logic apparent_quantum,
  input wire logic irms_quantum,
  // pins and request
  input wire logic pulse_out_a,
  input wire logic pulse_out_b,
  input wire logic energy_irq
);
  import etp_pkg::*;
  logic [7:0] cfg_one_reg;
  logic [7:0] en_mid_reg;
  int low_a_reg;
  logic any_q;
  assign any_q = active_quantum | reactive_quantum | apparent_quantum | irms_quantum;
  // ==========================================================
  // shadow registers, so masks can be judged at the ports
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cfg_one_reg <= 8'h00;
      en_mid_reg <= 8'h00;
    end else if (wr_strobe && addr == OFF_CONFIG_ONE) begin
      cfg_one_reg <= wr_data[7:0];
    end else if (wr_strobe && addr == OFF_IRQ_EN_MID) begin
      en_mid_reg <= wr_data[7:0];
    end
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) low_a_reg <= 0;
    else low_a_reg <= pulse_out_a ? 0 : low_a_reg + 1;
  end
  // ==========================================================
  // properties; latency windows carry a little slack for the prescaler stage
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  chk_pin_cause_a: assert property ($fell(pulse_out_a) |-> $past(any_q, 3) || $past(any_q, 4)
    || $past(any_q, 5)) else $error("pulse a fell without a quantum");
  chk_pin_cause_b: assert property ($fell(pulse_out_b) |-> $past(any_q, 3) || $past(any_q, 4)
    || $past(any_q, 5)) else $error("pulse b fell without a quantum");
  chk_dis_a: assert property (cfg_one_reg[1] && $past(cfg_one_reg[1], 3) |-> pulse_out_a)
    else $error("disabled pulse a not idle high");
  chk_dis_b: assert property (cfg_one_reg[2] && $past(cfg_one_reg[2], 3) |-> pulse_out_b)
    else $error("disabled pulse b not idle high");
  chk_irq_masked: assert property (energy_irq |-> $past(en_mid_reg[7:6]) != 2'b00)
    else $error("interrupt raised with its enables clear");
  chk_irq_rise: assert property ($rose(energy_irq) |-> $past(any_q, 3) || $past(any_q, 4)
    || $past(any_q, 5) || $past(wr_strobe, 2)) else $error("interrupt rose without cause");
  chk_irq_hold: assert property ($fell(energy_irq) |-> $past(wr_strobe, 2) || $past(wr_strobe))
    else $error("interrupt dropped without a register write");
  chk_low_max: assert property ($rose(pulse_out_a) |-> low_a_reg <= LOW_CYC)
    else $error("pulse a low phase too long");
endmodule
bind etp_converter etp_converter_asserts #(.LOW_CYC(LOW_CYC), .LONG_CYC(LONG_CYC)) u_chk (
  .clock(clock), .reset_n(reset_n), .addr(addr), .wr_data(wr_data), .wr_strobe(wr_strobe),
  .rd_strobe(rd_strobe), .rd_data(rd_data), .active_quantum(active_quantum),
  .reactive_quantum(reactive_quantum), .apparent_quantum(apparent_quantum), .irms_quantum(irms_quantum),
  .pulse_out_a(pulse_out_a), .pulse_out_b(pulse_out_b), .energy_irq(energy_irq));

// ==== testbench/etp_converter_tb.sv ====
// self-checking bench for the energy to pulse converter
`timescale 1ns/1ns
`define CHECK(got, exp) begin checked++; if ((got) !== (exp)) begin fails++; \
  $display("ERROR %0t: got %h expected %h", $time, got, exp); end end
module etp_converter_tb;
  import etp_pkg::*;
  localparam int LOW = 20;
  localparam int LONG = 40;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wr_data = 16'h0000;
  logic wr_strobe = 1'b0;
  logic rd_strobe = 1'b0;
  logic [15:0] rd_data;
  logic [3:0] quanta = 4'h0;
  logic pin_a;
  logic pin_b;
  logic irq;
  logic [15:0] cnt_a, cnt_b, low_a, low_b, ea, eb;
  logic [7:0] regs [10] = '{8'h0b, 8'h0c, 8'h27, 8'h28, 8'h29, 8'h2a, 8'hd9, 8'hda, 8'hdb, 8'hdd};
  int fails = 0;
  int checked = 0;
  always #10 clock = ~clock;
  etp_converter #(.LOW_CYC(LOW), .LONG_CYC(LONG)) uut (.clock(clock), .reset_n(reset_n), .addr(addr),
    .wr_data(wr_data), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data),
    .active_quantum(quanta[0]), .reactive_quantum(quanta[1]), .apparent_quantum(quanta[2]),
    .irms_quantum(quanta[3]), .pulse_out_a(pin_a), .pulse_out_b(pin_b), .energy_irq(irq));
  etp_cal_meter meter (.clock(clock), .reset_n(reset_n), .pin_a(pin_a), .pin_b(pin_b),
    .count_a(cnt_a), .count_b(cnt_b), .low_a(low_a), .low_b(low_b));
  // ==========================================================
  // bus and stimulus tasks
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wr_data <= d;
    wr_strobe <= 1'b1;
    @(posedge clock);
    wr_strobe <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clock);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge clock);
    rd_strobe <= 1'b0;
    #1;
    `CHECK(rd_data, exp)
  endtask
  task automatic pulse(input int k, input int gap);
    @(posedge clock);
    quanta[k] <= 1'b1;
    @(posedge clock);
    quanta <= 4'h0;
    repeat (gap) @(posedge clock);
  endtask
  function automatic int src_of(input logic [1:0] s, input logic h);
    return s[1] ? (h ? 3 : 2) : int'(s[0]);
  endfunction
  task automatic summarize();
    $display("checks %0d errors %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    summarize();
  end
  // ==========================================================
  // scenarios
  initial begin
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    foreach (regs[i]) rdc(regs[i], 16'h0000);
    wr(8'h50, 16'h00ff);
    rdc(8'h50, 16'h0000);
    wr(OFF_NUM_A, 16'hfffe);
    rdc(OFF_NUM_A, 16'hfffe);
    wr(OFF_NUM_A, 16'h0000);
    // zero num and den act as one, so every quantum gives a pulse
    for (int c = 0; c < 8; c++) begin
      wr(OFF_CONFIG_TWO, {8'h00, c[1:0] ^ 2'b01, c[1:0], c[2], 3'b000});
      for (int s = 0; s < 4; s++) begin
        ea = cnt_a;
        eb = cnt_b;
        pulse(s, 50);
        `CHECK(cnt_a - ea, 16'(src_of(c[1:0], c[2]) == s))
        `CHECK(cnt_b - eb, 16'(src_of(c[1:0] ^ 2'b01, c[2]) == s))
      end
    end
    `CHECK(low_a, 16'(LOW))
    wr(OFF_CONFIG_TWO, 16'h0000);
    wr(OFF_NUM_A, 16'h0001);
    wr(OFF_DEN_A, 16'h0003);
    wr(OFF_NUM_B, 16'h0005);
    wr(OFF_DEN_B, 16'h0002);
    ea = cnt_a;
    eb = cnt_b;
    repeat (9) pulse(0, 50);
    `CHECK(cnt_a - ea, 16'h0003)
    `CHECK(cnt_b - eb, 16'h0009)
    wr(OFF_NUM_A, 16'h0000);
    wr(OFF_DEN_A, 16'h0000);
    repeat (6) pulse(0, 8);
    repeat (60) @(posedge clock);
    `CHECK(low_a, 16'h0005)
    `CHECK(low_b, 16'h0005)
    for (int d = 0; d < 2; d++) begin
      wr(OFF_CONFIG_ONE, 16'(2 << d));
      ea = cnt_a;
      eb = cnt_b;
      pulse(0, 50);
      `CHECK(cnt_a - ea, 16'(d))
      `CHECK(cnt_b - eb, 16'(1 - d))
    end
    wr(OFF_CONFIG_ONE, 16'h0000);
    ea = cnt_a;
    pulse(0, 50);
    `CHECK(cnt_a - ea, 16'h0001)
    rdc(OFF_IRQ_STATUS_MID, 16'h00c0);
    `CHECK(irq, 1'b0)
    wr(OFF_IRQ_STATUS_MID, 16'h00ff);
    rdc(OFF_IRQ_STATUS_MID, 16'h00c0);
    wr(OFF_IRQ_EN_MID, 16'h0040);
    repeat (3) @(posedge clock);
    `CHECK(irq, 1'b1)
    wr(OFF_IRQ_STATUS_MID, 16'h007f);
    rdc(OFF_IRQ_STATUS_MID, 16'h0040);
    `CHECK(irq, 1'b1)
    wr(OFF_IRQ_STATUS_MID, 16'h00bf);
    repeat (3) @(posedge clock);
    `CHECK(irq, 1'b0)
    wr(OFF_CONFIG_TWO, 16'h0010);
    wr(OFF_IRQ_EN_MID, 16'h0080);
    pulse(1, 50);
    rdc(OFF_IRQ_STATUS_MID, 16'h0040);
    `CHECK(irq, 1'b0)
    pulse(0, 50);
    `CHECK(irq, 1'b1)
    rdc(OFF_PULSE_STATE, 16'h002f);
    rdc(OFF_COUNT_A, 16'h0014);
    // divider 1 passes every quantum, divider 2 every second one
    for (int v = 1; v < 3; v++) begin
      wr(OFF_DIVIDER, 16'(v));
      eb = cnt_b;
      repeat (v) pulse(0, 50);
      `CHECK(cnt_b - eb, 16'h0001)
    end
    rdc(OFF_COUNT_B, 16'h001c);
    summarize();
  end
endmodule
